// file: verilog/scpd_consts.vh
// Constants for the eight-channel switch protection and diagnosis block
`ifndef SCPD_CONSTS_VH
`define SCPD_CONSTS_VH

// Clock period of the device clock
`define SCPD_CLK_PERIOD_NS 100

// Over load shut-down delay, longest time, rounded down to cycles
`define SCPD_OVL_DELAY_NS  60000
`define SCPD_OVL_CYCLES    (`SCPD_OVL_DELAY_NS / `SCPD_CLK_PERIOD_NS)

// Open load diagnosis delay, least time, rounded up to cycles
`define SCPD_OL_DELAY_NS   100000
`define SCPD_OL_CYCLES     ((`SCPD_OL_DELAY_NS + `SCPD_CLK_PERIOD_NS - 1) / `SCPD_CLK_PERIOD_NS)

// Register banks
`define SCPD_BANK_CFG      1'b0
`define SCPD_BANK_DIAG     1'b1

// Bank 0 offsets
`define SCPD_ADDR_INSEL01  3'h0
`define SCPD_ADDR_INSEL23  3'h1
`define SCPD_ADDR_INSEL45  3'h2
`define SCPD_ADDR_INSEL67  3'h3
`define SCPD_ADDR_DCCR0    3'h4
`define SCPD_ADDR_DCCR1    3'h5
`define SCPD_ADDR_CMD      3'h6

// Command register fields
`define SCPD_CMD_CPL_BIT   0

// Input select codes
`define SCPD_SEL_OFF       2'h0
`define SCPD_SEL_IN1       2'h1
`define SCPD_SEL_IN2       2'h2
`define SCPD_SEL_ON        2'h3

// Reset values
`define SCPD_INSEL_RST     16'h0000
`define SCPD_DCEN_RST      8'h00
`define SCPD_CMD_RST       4'h0

`endif

// file: verilog/scpd_channel.v
// One switch channel: protection latch, fault flag and open load flag
`timescale 1ns/1ps
`include "scpd_consts.vh"

module scpd_channel #(
  parameter OVL_CYCLES = `SCPD_OVL_CYCLES,
  parameter OL_CYCLES  = `SCPD_OL_CYCLES,
  parameter CNT_W      = 12
) (
  input  wire clk,
  input  wire rstn,
  input  wire onRequest,
  input  wire overLoad,
  input  wire overTemp,
  input  wire openLoadInd,
  input  wire clearLatch,
  input  wire readClear,
  output reg  driveOn_reg,
  output reg  faultFlag_reg,
  output reg  openLoadFlag_reg
);

  // Last count of each delay, cut to the counter width on purpose
  localparam integer     OVL_LAST_I = OVL_CYCLES - 1;
  localparam integer     OL_LAST_I  = OL_CYCLES - 1;
  localparam [CNT_W-1:0] OVL_LAST   = OVL_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] OL_LAST    = OL_LAST_I[CNT_W-1:0];

  reg  [CNT_W-1:0] ovlCnt_reg;
  reg  [CNT_W-1:0] olCnt_reg;
  reg              protLatch_reg;
  wire             ovlTrip;
  wire             otTrip;
  wire             olSet;
  wire             latchNext;

  // Over load must persist the whole delay while the channel drives
  assign ovlTrip   = overLoad && driveOn_reg && (ovlCnt_reg == OVL_LAST);
  // Over temperature also holds a latch that is already set, so a clear
  // written while the channel is still hot cannot release it
  assign otTrip    = overTemp && (driveOn_reg || protLatch_reg);
  // Open load is judged only in the off state
  assign olSet     = openLoadInd && !driveOn_reg && (olCnt_reg == OL_LAST);
  // A fault in the cycle of a clear keeps the latch set
  assign latchNext = (ovlTrip || otTrip) ? 1'b1 :
                     (clearLatch ? 1'b0 : protLatch_reg);

  // Delay counters restart whenever their condition drops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovlCnt_reg <= {CNT_W{1'b0}};
      olCnt_reg  <= {CNT_W{1'b0}};
    end else begin
      if (overLoad && driveOn_reg && ovlCnt_reg != OVL_LAST)
        ovlCnt_reg <= ovlCnt_reg + 1'b1;
      else if (!(overLoad && driveOn_reg))
        ovlCnt_reg <= {CNT_W{1'b0}};
      // Saturates so a persistent open load shows again after a read
      if (openLoadInd && !driveOn_reg && olCnt_reg != OL_LAST)
        olCnt_reg <= olCnt_reg + 1'b1;
      else if (!(openLoadInd && !driveOn_reg))
        olCnt_reg <= {CNT_W{1'b0}};
    end
  end

  // Latch, drive and flags; every set wins over its clear
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      protLatch_reg    <= 1'b0;
      driveOn_reg      <= 1'b0;
      faultFlag_reg    <= 1'b0;
      openLoadFlag_reg <= 1'b0;
    end else begin
      protLatch_reg <= latchNext;
      driveOn_reg   <= onRequest && !latchNext;
      if (ovlTrip || overTemp)
        faultFlag_reg <= 1'b1;
      else if (clearLatch)
        faultFlag_reg <= 1'b0;
      if (olSet)
        openLoadFlag_reg <= 1'b1;
      else if (readClear)
        openLoadFlag_reg <= 1'b0;
    end
  end

endmodule // scpd_channel

// file: verilog/scpd_switch_top.v
// Eight-channel switch control: register file, input mux and channel protection
`timescale 1ns/1ps
`include "scpd_consts.vh"

module scpd_switch_top #(
  parameter NUM_CH     = 8,
  parameter OVL_CYCLES = `SCPD_OVL_CYCLES,
  parameter OL_CYCLES  = `SCPD_OL_CYCLES
) (
  input  wire              clk,
  input  wire              rstn,
  input  wire              in1,
  input  wire              in2,
  input  wire [NUM_CH-1:0] overLoad,
  input  wire [NUM_CH-1:0] overTemp,
  input  wire [NUM_CH-1:0] openLoadInd,
  input  wire              frameValid,
  input  wire              frameWrite,
  input  wire              frameBank,
  input  wire [2:0]        frameAddr,
  input  wire [3:0]        frameWrData,
  output reg  [3:0]        rdData_reg,
  output wire [NUM_CH-1:0] chDrive,
  output reg  [NUM_CH-1:0] diagCurrentEn_reg,
  output reg  [3:0]        cmd_reg
);

  localparam        NUM_PAIR  = NUM_CH / 2;
  localparam        PAIR_W    = 2;
  localparam [15:0] INSEL_RST = `SCPD_INSEL_RST;

  // Register map of the configuration bank (bank 0)
  //   0..3  input select words: channel 2k in bits 1:0, channel 2k+1 in bits 3:2
  //   4..5  diagnosis current enables, four channels per word
  //   6     command word: bit 0 is the clear-latch bit, the rest are stored only
  //   7     unmapped: reads as zero, writes are dropped
  // Diagnosis bank (bank 1), read only
  //   0..3  {open load 2k+1, fault 2k+1, open load 2k, fault 2k}
  //   4..7  unmapped: reads as zero, and a read there clears no open-load flag

  // Register storage and per-channel results
  reg  [3:0]          inputSelect_reg [0:NUM_PAIR-1];
  reg  [3:0]          cfgRdData;
  reg  [3:0]          diagRdData;
  wire [3:0]          rdData_next;
  wire [NUM_CH-1:0]   onRequest;
  wire [NUM_CH-1:0]   readClear;
  wire [NUM_CH-1:0]   faultFlag;
  wire [NUM_CH-1:0]   openLoadFlag;
  wire [2*NUM_CH-1:0] diagWordFlat;
  // Frame decode
  wire                writeFrame;
  wire                readFrame;
  wire                cfgWrite;
  wire                diagRead;
  wire                selHit;
  wire                dcenHit;
  wire                cmdWrite;
  wire                cplWrite;
  wire                cplClear;
  wire [PAIR_W-1:0]   pairIndex;
  wire                dcenIndex;
  integer             w;

  // A frame is either a write or a read; frameValid lasts one cycle
  assign writeFrame = frameValid && frameWrite;
  assign readFrame  = frameValid && !frameWrite;
  assign cfgWrite   = writeFrame && (frameBank == `SCPD_BANK_CFG);
  // Address groups; the diagnosis bank only decodes its low half
  assign selHit     = (frameAddr[2] == 1'b0);
  assign dcenHit    = (frameAddr == `SCPD_ADDR_DCCR0) || (frameAddr == `SCPD_ADDR_DCCR1);
  assign pairIndex  = frameAddr[PAIR_W-1:0];
  assign dcenIndex  = frameAddr[0];
  assign cmdWrite   = cfgWrite && (frameAddr == `SCPD_ADDR_CMD);
  // Reads of the diagnosis bank clear the open-load flags they return
  assign diagRead   = readFrame && (frameBank == `SCPD_BANK_DIAG) && selHit;
  // Latch clear acts once, on the frame that writes the bit; later frames
  // only drop the stored copy, so a stale bit can never clear a new fault
  assign cplWrite   = cmdWrite && frameWrData[`SCPD_CMD_CPL_BIT];
  assign cplClear   = cplWrite;

  // Input select words, one per channel pair, written by index
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (w = 0; w < NUM_PAIR; w = w + 1)
        inputSelect_reg[w] <= INSEL_RST[4*w +: 4];
    end else if (cfgWrite && selHit) begin
      inputSelect_reg[pairIndex] <= frameWrData;
    end
  end

  // Diagnosis current enables; the output current follows these bits directly
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      diagCurrentEn_reg <= `SCPD_DCEN_RST;
    else if (cfgWrite && dcenHit)
      diagCurrentEn_reg[4*dcenIndex +: 4] <= frameWrData;
  end

  // Command word; the clear-latch bit drops on the next valid frame of any
  // kind unless that frame rewrites the command word
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      cmd_reg <= `SCPD_CMD_RST;
    else if (cmdWrite)
      cmd_reg <= frameWrData;
    else if (frameValid)
      cmd_reg[`SCPD_CMD_CPL_BIT] <= 1'b0;
  end

  // Configuration bank read mux
  always @* begin
    case (frameAddr)
      `SCPD_ADDR_INSEL01: cfgRdData = inputSelect_reg[0];
      `SCPD_ADDR_INSEL23: cfgRdData = inputSelect_reg[1];
      `SCPD_ADDR_INSEL45: cfgRdData = inputSelect_reg[2];
      `SCPD_ADDR_INSEL67: cfgRdData = inputSelect_reg[3];
      `SCPD_ADDR_DCCR0:   cfgRdData = diagCurrentEn_reg[3:0];
      `SCPD_ADDR_DCCR1:   cfgRdData = diagCurrentEn_reg[7:4];
      `SCPD_ADDR_CMD:     cfgRdData = cmd_reg;
      default:            cfgRdData = 4'h0;
    endcase
  end

  // Diagnosis bank read mux; flags show as they stood before the read clears them
  always @* begin
    diagRdData = 4'h0;
    if (selHit)
      diagRdData = diagWordFlat[4*pairIndex +: 4];
  end

  assign rdData_next = (frameBank == `SCPD_BANK_DIAG) ? diagRdData : cfgRdData;

  // Read data is captured once per read frame and held until the next one
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      rdData_reg <= 4'h0;
    else if (readFrame)
      rdData_reg <= rdData_next;
  end

  // Per channel: input multiplexer, flag packing and protection slice
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : gChannel
      wire [1:0] selCode;
      // Two-bit select field of this channel inside its pair word
      assign selCode = inputSelect_reg[ch / 2][2 * (ch % 2) +: 2];
      // Code 00 is off; an input pin high is an on command, low an off command
      assign onRequest[ch] = (selCode == `SCPD_SEL_ON) ||
                             ((selCode == `SCPD_SEL_IN1) && in1) ||
                             ((selCode == `SCPD_SEL_IN2) && in2);
      // Diagnosis word bits of this channel: open load above fault
      assign diagWordFlat[2 * ch +: 2] = {openLoadFlag[ch], faultFlag[ch]};
      // The read that returns this channel's flags also clears its open load
      assign readClear[ch] = diagRead && (pairIndex == ch / 2);
      scpd_channel #(
        .OVL_CYCLES (OVL_CYCLES),
        .OL_CYCLES  (OL_CYCLES),
        .CNT_W      (12)
      ) uChannel (
        .clk              (clk),
        .rstn             (rstn),
        .onRequest        (onRequest[ch]),
        .overLoad         (overLoad[ch]),
        .overTemp         (overTemp[ch]),
        .openLoadInd      (openLoadInd[ch]),
        .clearLatch       (cplClear),
        .readClear        (readClear[ch]),
        .driveOn_reg      (chDrive[ch]),
        .faultFlag_reg    (faultFlag[ch]),
        .openLoadFlag_reg (openLoadFlag[ch])
      );
    end
  endgenerate

endmodule // scpd_switch_top

// file: dv/scpd_host_model.sv
// Serial host stand-in that issues decoded register frames
`timescale 1ns/1ps
module scpd_host_model (
  input  wire       clk,
  output reg        frameValid,
  output reg        frameWrite,
  output reg        frameBank,
  output reg  [2:0] frameAddr,
  output reg  [3:0] frameWrData
);
  initial {frameValid, frameWrite, frameBank, frameAddr, frameWrData} = 10'h000;

  // One-cycle frame; released lines show inverted values so stale data never matches
  task xfer(input w, input b, input [2:0] a, input [3:0] d);
    begin
      @(posedge clk) #1;
      {frameValid, frameWrite, frameBank, frameAddr, frameWrData} = {1'b1, w, b, a, d};
      @(posedge clk) #1;
      {frameValid, frameWrite, frameBank, frameAddr, frameWrData} = {1'b0, ~w, ~b, ~a, ~d};
    end
  endtask

  // Host releases a protection latch only by writing the clear bit as 1
  task clearLatch;
    xfer(1'b1, 1'b0, 3'h6, 4'h1);
  endtask
endmodule // scpd_host_model

// file: dv/scpd_chk.sv
// Assertion checker for the switch protection block, sized for OVL_CYCLES of 4
`timescale 1ns/1ps
module scpd_chk (
  input wire       clk,
  input wire       rstn,
  input wire [7:0] overLoad,
  input wire [7:0] overTemp,
  input wire       frameValid,
  input wire       frameWrite,
  input wire       frameBank,
  input wire [2:0] frameAddr,
  input wire [3:0] frameWrData,
  input wire [3:0] rdData_reg,
  input wire [7:0] chDrive,
  input wire [7:0] diagCurrentEn_reg,
  input wire [3:0] cmd_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Frame decodes
  wire cplWr  = frameValid && frameWrite && !frameBank && frameAddr == 3'h6 && frameWrData[0];
  wire rdDiag = frameValid && !frameWrite && frameBank && frameAddr == 3'h1;

  chk_overload_trip: assert property ((overLoad[0] && chDrive[0]) [*4] |=> !chDrive[0])
    else $error("over load did not switch channel off");
  chk_overtemp_off: assert property (chDrive[2] && overTemp[2] |=> !chDrive[2])
    else $error("over temperature did not switch channel off");
  chk_latch_hold: assert property (chDrive[2] && overTemp[2] ##1 !cplWr [*3] |-> !chDrive[2])
    else $error("latched channel came back on");
  chk_fault_flag: assert property (overTemp[2] ##1 rdDiag |=> rdData_reg[0])
    else $error("fault flag missing after over temperature");
  chk_cpl_set: assert property (cplWr |=> cmd_reg[0])
    else $error("clear bit not stored");
  chk_cpl_self_clear: assert property (frameValid && !cplWr && cmd_reg[0] |=> !cmd_reg[0])
    else $error("clear bit did not return to zero");
  chk_diag_enable: assert property (frameValid && frameWrite && !frameBank && frameAddr == 3'h4
    |=> diagCurrentEn_reg[3:0] == $past(frameWrData))
    else $error("diagnosis current enable not written");
  chk_unmapped_read: assert property (frameValid && !frameWrite && !frameBank && frameAddr == 3'h7
    |=> rdData_reg == 4'h0)
    else $error("unmapped read not zero");
  cover property (cplWr);
  cover property ((overLoad[0] && chDrive[0]) [*4]);
  cover property (rdDiag);
endmodule // scpd_chk

bind scpd_switch_top scpd_chk scpd_chk_inst (.clk, .rstn, .overLoad, .overTemp, .frameValid,
  .frameWrite, .frameBank, .frameAddr, .frameWrData, .rdData_reg, .chDrive, .diagCurrentEn_reg,
  .cmd_reg);

// file: dv/scpd_switch_bench.sv
// Self-checking bench with a cycle reference model of the switch block
`timescale 1ns/1ps
module scpd_switch_bench;
  localparam OVL = 4, OL = 8;
  reg        clk = 0, rstn = 0, in1 = 0, in2 = 0;
  reg  [7:0] overLoad = 8'h00, overTemp = 8'h00, openLoadInd = 8'h00;
  wire       frameValid, frameWrite, frameBank;
  wire [2:0] frameAddr;
  wire [3:0] frameWrData, rdData_reg, cmd_reg;
  wire [7:0] chDrive, diagCurrentEn_reg;
  int        err_count = 0, num_checks = 0, cyc = 0, i, c, a, oc[8], lc[8];
  bit  [1:0] sel[8];
  bit        lat[8], flt[8], ol[8], clear_protection_latch, lk;
  reg  [7:0] mDrv, mDcen;
  reg  [3:0] mCmd, mRd;
  reg [31:0] seed = 32'h77d0_8bad;

  scpd_switch_top #(.NUM_CH(8), .OVL_CYCLES(OVL), .OL_CYCLES(OL)) scpd_switch_top_inst (.clk,
    .rstn, .in1, .in2, .overLoad, .overTemp, .openLoadInd, .frameValid, .frameWrite, .frameBank,
    .frameAddr, .frameWrData, .rdData_reg, .chDrive, .diagCurrentEn_reg, .cmd_reg);
  scpd_host_model scpd_host_model_inst (.clk, .frameValid, .frameWrite, .frameBank, .frameAddr,
    .frameWrData);

  always #50 clk = ~clk;
  // Hang guard: the sequence needs well under 1000 cycles
  always @(posedge clk) if (++cyc == 2000) begin
    err_count++;
    end_sim;
  end

  // Reference model, one step per edge from values before the edge
  always @(posedge clk or negedge rstn) if (!rstn) begin
    {mDrv, mDcen, mCmd, mRd} = 24'h00_0000;
    for (c = 0; c < 8; c++) {sel[c], lat[c], flt[c], ol[c], oc[c], lc[c]} = 0;
  end else begin
    a = frameAddr;
    clear_protection_latch = frameValid && frameWrite && !frameBank && a == 6 && frameWrData[0];
    if (frameValid && !frameWrite) begin
      if (frameBank) mRd = a < 4 ? {ol[2*a+1], flt[2*a+1], ol[2*a], flt[2*a]} : 4'h0;
      else mRd = a < 4 ? {sel[2*a+1], sel[2*a]} : a < 6 ? mDcen[4*(a-4)+:4] : a == 6 ? mCmd : 4'h0;
      if (frameBank && a < 4) {ol[2*a+1], ol[2*a]} = 2'b00;
    end
    if (frameValid && frameWrite && !frameBank && (a == 4 || a == 5)) mDcen[4*(a-4)+:4] = frameWrData;
    if (frameValid && frameWrite && !frameBank && a == 6) mCmd = frameWrData;
    else if (frameValid) mCmd[0] = 0;
    for (c = 0; c < 8; c++) begin
      lk = lat[c];
      if (clear_protection_latch) {lat[c], flt[c]} = 2'b00;
      if (overTemp[c]) {lat[c], flt[c]} = {lat[c] | mDrv[c] | lk, 1'b1};
      oc[c] = overLoad[c] && mDrv[c] ? oc[c] + 1 : 0;
      if (oc[c] >= OVL) {lat[c], flt[c]} = 2'b11;
      lc[c] = openLoadInd[c] && !mDrv[c] ? lc[c] + 1 : 0;
      if (lc[c] >= OL) ol[c] = 1;
      mDrv[c] = (sel[c] == 3 || sel[c] == 1 && in1 || sel[c] == 2 && in2) && !lat[c];
    end
    // A select write reaches the drive one edge after it lands
    if (frameValid && frameWrite && !frameBank && a < 4) {sel[2*a+1], sel[2*a]} = frameWrData;
  end

  function automatic [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      num_checks++;
      if (g !== e) begin
        err_count++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // Let settled outputs land, then compare the drive, enable and command outputs
  task look(input int n);
    begin
      repeat (n) @(posedge clk);
      #1;
      chk("drive", mDrv, chDrive);
      chk("dcen", mDcen, diagCurrentEn_reg);
      chk("cmd", {4'h0, mCmd}, {4'h0, cmd_reg});
    end
  endtask
  task wr(input [2:0] ad, input [3:0] d);
    scpd_host_model_inst.xfer(1'b1, 1'b0, ad, d);
  endtask
  task rd(input b, input [2:0] ad);
    begin
      scpd_host_model_inst.xfer(1'b0, b, ad, 4'h0);
      chk("rdData", {4'h0, mRd}, {4'h0, rdData_reg});
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1 rstn = 1;
    look(1);
    // Random selects, enables and input levels
    for (i = 0; i < 16; i++) begin
      seed = xs(seed);
      {in1, in2} = seed[1:0];
      wr(3'(i % 6), seed[7:4]);
      look(3);
    end
    wr(3'h0, 4'h4);
    wr(3'h1, 4'hE);
    rd(1'b0, 3'h1);
    {in1, in2} = 2'b10;
    look(3);
    for (i = 0; i < 4; i++) wr(3'(i), 4'hF);
    overLoad[0] = 1;
    look(2);
    overLoad[0] = 0;
    look(2);
    overLoad[0] = 1;
    look(8);
    overLoad[0] = 0;
    look(5);
    rd(1'b1, 3'h0);
    scpd_host_model_inst.clearLatch;
    look(3);
    rd(1'b1, 3'h0);
    wr(3'h1, 4'h3);
    overTemp[3:2] = 2'b11;
    look(3);
    scpd_host_model_inst.clearLatch;
    look(3);
    rd(1'b1, 3'h1);
    overTemp = 8'h00;
    scpd_host_model_inst.clearLatch;
    look(3);
    wr(3'h2, 4'h3);
    openLoadInd[5:4] = 2'b11;
    look(12);
    openLoadInd = 8'h00;
    rd(1'b1, 3'h2);
    rd(1'b1, 3'h2);
    scpd_host_model_inst.xfer(1'b1, 1'b1, 3'h0, 4'hF);
    wr(3'h7, 4'hF);
    rd(1'b0, 3'h7);
    rd(1'b1, 3'h5);
    look(2);
    end_sim;
  end
endmodule // scpd_switch_bench
